// >>> rtl/sram_host.sv
// Host controller that runs read and write cycles on an asynchronous static memory.
`timescale 1ns/1ps
`include "sram_ctrl_map.svh"
module sram_host
    import sram_ctrl_pkg::*;
#(
    parameter int AW = 17,
    parameter int DW = 8
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          req_valid,
    input  wire logic          req_write,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_wdata,
    output logic               req_ready,
    output logic               rsp_valid,
    output logic [DW-1:0]      rsp_rdata,
    output logic [AW-1:0]      mem_addr,
    output logic               select_active_low,
    output logic               select_active_high,
    output logic               write_strobe_n,
    output logic               out_enable_n,
    input  wire logic [DW-1:0] mem_data_in,
    output logic [DW-1:0]      mem_data_out,
    output logic               mem_data_oe_n
);
    // ****************************************
    // Pin input synchroniser
    // ****************************************
    logic [DW-1:0] data_meta;
    logic [DW-1:0] data_sync;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_meta <= '0;
            data_sync <= '0;
        end else begin
            data_meta <= mem_data_in;
            data_sync <= data_meta;
        end
    end

    // ****************************************
    // Phase sequencer
    // ****************************************
    // Two extra cycles in the read let data pass the synchroniser before capture.
    localparam logic [3:0] READ_WAIT  = 4'(`READ_CYC + 2);
    localparam logic [3:0] TURN_WAIT  = 4'(`TURN_CYC);
    localparam logic [3:0] WRITE_WAIT = 4'(`PULSE_CYC > `SETUP_CYC ? `PULSE_CYC : `SETUP_CYC);
    localparam logic [3:0] IDLE_WAIT  = 4'(`IDLE_CYC);

    phase_e     phase;
    phase_e     next_phase;
    logic       timer_done;
    logic       timer_load;
    logic [3:0] timer_count;
    logic       take_req;
    logic       wr_busy;

    assign take_req = (phase == ST_IDLE) && req_valid && timer_done;
    assign wr_busy  = (phase == ST_TURN) || (phase == ST_WRITE);

    always_comb begin
        next_phase  = phase;
        timer_load  = 1'b0;
        timer_count = 4'h0;
        case (phase)
            ST_IDLE: begin
                if (take_req) begin
                    timer_load = 1'b1;
                    if (req_write) begin
                        // Output enable is already high here; the turn phase keeps the margin anyway.
                        next_phase  = ST_TURN;
                        timer_count = TURN_WAIT;
                    end else begin
                        next_phase  = ST_READ;
                        timer_count = READ_WAIT;
                    end
                end
            end
            ST_READ: begin
                if (timer_done) begin
                    next_phase  = ST_RECOVER;
                    timer_load  = 1'b1;
                    timer_count = IDLE_WAIT;
                end
            end
            ST_TURN: begin
                if (timer_done) begin
                    next_phase  = ST_WRITE;
                    timer_load  = 1'b1;
                    timer_count = WRITE_WAIT;
                end
            end
            ST_WRITE: begin
                if (timer_done) begin
                    next_phase  = ST_RECOVER;
                    timer_load  = 1'b1;
                    timer_count = IDLE_WAIT;
                end
            end
            ST_RECOVER: begin
                if (timer_done) begin
                    next_phase = ST_IDLE;
                end
            end
            default: begin
                next_phase = ST_IDLE;
            end
        endcase
    end

    cycle_timer #(
        .W(4)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst    (rst),
        .load   (timer_load),
        .count  (timer_count),
        .done   (timer_done)
    );

    // ****************************************
    // Pin drivers
    // ****************************************
    // Selects only drop in idle, so both frame each whole write phase.
    logic next_selected;
    logic next_strobe_n;
    logic next_oe_n;
    logic next_drive_n;
    assign next_selected = (next_phase != ST_IDLE);
    assign next_strobe_n = !(next_phase == ST_WRITE);
    assign next_oe_n     = !(next_phase == ST_READ);
    assign next_drive_n  = !((next_phase == ST_TURN) || (next_phase == ST_WRITE) ||
                             (phase == ST_WRITE));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase              <= ST_IDLE;
            select_active_low  <= 1'b1;
            select_active_high <= 1'b0;
            write_strobe_n     <= 1'b1;
            out_enable_n       <= 1'b1;
            mem_data_oe_n      <= 1'b1;
        end else begin
            phase              <= next_phase;
            select_active_low  <= !next_selected;
            select_active_high <= next_selected;
            write_strobe_n     <= next_strobe_n;
            out_enable_n       <= next_oe_n;
            mem_data_oe_n      <= next_drive_n;
        end
    end

    // Address and data hold through recovery, so they outlast the end of the write.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem_addr     <= '0;
            mem_data_out <= '0;
        end else if (take_req) begin
            mem_addr     <= req_addr;
            mem_data_out <= req_wdata;
        end
    end

    // ****************************************
    // Request and answer handshake
    // ****************************************
    logic read_end;
    assign read_end = (phase == ST_READ) && timer_done;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            req_ready <= (next_phase == ST_IDLE) && !take_req;
            rsp_valid <= read_end;
            if (read_end) begin
                rsp_rdata <= data_sync;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    strobe_in_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        !out_enable_n |-> write_strobe_n)
        else $error("Strobe low during a read.");
    strobe_selected_a: assert property (@(posedge clk_sys) disable iff (rst)
        !write_strobe_n |-> (!select_active_low && select_active_high))
        else $error("Strobe low without both selects.");
    select_frame_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(write_strobe_n) |-> $past(!select_active_low))
        else $error("Selects not active before the strobe fell.");
    no_contention_a: assert property (@(posedge clk_sys) disable iff (rst)
        !mem_data_oe_n |-> out_enable_n)
        else $error("Host drives data while output enable is low.");
    turn_before_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(write_strobe_n) |-> $past(!mem_data_oe_n))
        else $error("Data not driven before the strobe fell.");
    pulse_width_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(write_strobe_n) |-> !write_strobe_n [*2])
        else $error("Write pulse too short.");
    data_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(write_strobe_n) |-> !mem_data_oe_n && $stable(mem_data_out) && $stable(mem_addr))
        else $error("Data or address changed at write end.");
    read_answer_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(out_enable_n) |-> ##[1:6] rsp_valid)
        else $error("Read answer late.");
    select_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(write_strobe_n) |-> !select_active_low)
        else $error("Select dropped with the strobe.");
endmodule // sram_host

// >>> rtl/sram_ctrl_map.svh
// Constants for the asynchronous static memory host controller.
`ifndef SRAM_CTRL_MAP_SVH
`define SRAM_CTRL_MAP_SVH
// ****************************************
// Timing figures of the slowest grade, ns
// ****************************************
`define CLK_PERIOD_NS     40
`define T_ACCESS_NS       20
`define T_SEL_WRITE_NS    15
`define T_WRITE_PULSE_NS  15
`define T_STROBE_OFF_NS   8
`define T_DATA_SETUP_NS   9
`define T_ADDR_WRITE_NS   15
`define T_OE_OFF_NS       7
`define T_RECOVERY_NS     0
// ****************************************
// Cycle counts, least times round up
// ****************************************
`define CEIL_CYC(t)       (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC          ((`CEIL_CYC(`T_ACCESS_NS) < 1) ? 1 : `CEIL_CYC(`T_ACCESS_NS))
`define TURN_CYC          ((`CEIL_CYC(`T_STROBE_OFF_NS) < 1) ? 1 : `CEIL_CYC(`T_STROBE_OFF_NS))
`define SETUP_CYC         ((`CEIL_CYC(`T_DATA_SETUP_NS) < 1) ? 1 : `CEIL_CYC(`T_DATA_SETUP_NS))
`define PULSE_CYC         ((`CEIL_CYC(`T_WRITE_PULSE_NS) < 1) ? 1 : `CEIL_CYC(`T_WRITE_PULSE_NS))
`define IDLE_CYC          ((`CEIL_CYC(`T_OE_OFF_NS) < 1) ? 1 : `CEIL_CYC(`T_OE_OFF_NS))
`endif

// >>> rtl/sram_ctrl_pkg.sv
// Types shared by the memory host controller.
package sram_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_TURN,
        ST_WRITE,
        ST_RECOVER
    } phase_e;
endpackage

// >>> rtl/cycle_timer.sv
// Down counter that times each bus phase.
`timescale 1ns/1ps
module cycle_timer #(
    parameter int W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              done
);
    logic [W-1:0] remain;
    assign done = (remain == '0);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (!done) begin
            remain <= remain - W'(1);
        end
    end
endmodule // cycle_timer

// >>> testbench/sram_model.sv
// Behavioural model of the asynchronous static memory facing the host.
`timescale 1ns/1ps
module sram_model (
    input  wire logic [16:0] addr,
    input  wire logic        sel_n,
    input  wire logic        sel,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic [7:0]  din,
    output logic [7:0]       dout,
    output logic             drive
);
    // ****************************************
    // Storage and pin decode
    // ****************************************
    logic [7:0] mem [0:131071];
    wire        selected = !sel_n && sel;
    wire        wr       = selected && !we_n;
    wire        rd       = selected && we_n && !oe_n;
    initial drive = 1'b0;
    // The write is level sensitive, so a host that moves the address while the strobe is low corrupts memory.
    always @* begin
        if (wr) mem[addr] = din;
    end
    always @(rd) begin
        if (rd) drive <= #3 1'b1;
        else drive <= #5 1'b0;
    end
    // Slowest grade access; the old byte stays until the new one settles.
    assign #20 dout = mem[addr];
endmodule // sram_model

// >>> testbench/tb.sv
// Self-checking bench for the memory host controller against a behavioural memory.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
    import sram_ctrl_pkg::*;
    // ****************************************
    // Signals, design and memory
    // ****************************************
    logic        clk_sys   = 1'b0;
    logic        rst       = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [16:0] req_addr  = 17'h00000;
    logic [7:0]  req_wdata = 8'h00;
    logic        req_ready, rsp_valid, select_active_low, select_active_high;
    logic        write_strobe_n, out_enable_n, mem_data_oe_n, drive;
    logic [7:0]  rsp_rdata, mem_data_out, dout, prev_data;
    logic [7:0]  bus_last  = 8'h00;
    logic [16:0] mem_addr, prev_addr, a;
    logic [31:0] seed      = 32'h01E1;
    logic [7:0]  exp_mem [logic [16:0]];
    int          errors    = 0;
    int          checks    = 0;
    // A released bus shows the inverse of its last level, so stale data never reads as good.
    wire  [7:0]  bus = !mem_data_oe_n ? mem_data_out : drive ? dout : ~bus_last;
    always @(bus) if (!mem_data_oe_n || drive) bus_last = bus;
    always #20 clk_sys = ~clk_sys;
    sram_host u_sram_host (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .select_active_low(select_active_low),
        .select_active_high(select_active_high), .write_strobe_n(write_strobe_n), .out_enable_n(out_enable_n),
        .mem_data_in(bus), .mem_data_out(mem_data_out), .mem_data_oe_n(mem_data_oe_n));
    sram_model u_sram_model (.addr(mem_addr), .sel_n(select_active_low), .sel(select_active_high),
        .we_n(write_strobe_n), .oe_n(out_enable_n), .din(bus), .dout(dout), .drive(drive));
    // ****************************************
    // Pin monitor and helpers
    // ****************************************
    always @(negedge clk_sys) begin
        if (!rst) begin
            if (!write_strobe_n) begin
                `CHK("sel_low", 1'b0, select_active_low)
                `CHK("sel_high", 1'b1, select_active_high)
                `CHK("host_drive", 1'b0, mem_data_oe_n)
                `CHK("addr_hold", prev_addr, mem_addr)
                `CHK("data_hold", prev_data, mem_data_out)
            end
            if (!out_enable_n) `CHK("strobe_read", 1'b1, write_strobe_n)
            if (!mem_data_oe_n) `CHK("contention", 1'b0, drive)
        end
        prev_addr = mem_addr;
        prev_data = mem_data_out;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic do_op(input logic wr, input logic [16:0] ad, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk_sys);
        req_valid = 1'b1;
        req_write = wr;
        req_addr  = ad;
        req_wdata = d;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        `CHK("req_ready", 1'b1, req_ready)
        @(negedge clk_sys);
        req_valid = 1'b0;
        if (wr) exp_mem[ad] = d;
        else begin
            n = 0;
            while (rsp_valid !== 1'b1 && n < 50) begin
                @(negedge clk_sys);
                n++;
            end
            `CHK("rsp_valid", 1'b1, rsp_valid)
            `CHK("rdata", exp_mem[ad], rsp_rdata)
        end
    endtask
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (16) @(negedge clk_sys);
        `CHK("rst_sel_low", 1'b1, select_active_low)
        `CHK("rst_sel_high", 1'b0, select_active_high)
        `CHK("rst_strobe", 1'b1, write_strobe_n)
        `CHK("rst_out_enable", 1'b1, out_enable_n)
        `CHK("rst_host_drive", 1'b1, mem_data_oe_n)
        rst = 1'b0;
        do_op(1'b1, 17'h00000, 8'h00);
        do_op(1'b1, 17'h1FFFF, 8'hFF);
        do_op(1'b0, 17'h00000, 8'h00);
        do_op(1'b0, 17'h1FFFF, 8'h00);
        do_op(1'b1, 17'h00000, 8'hA5);
        do_op(1'b0, 17'h00000, 8'h00);
        for (int i = 0; i < 60; i++) begin
            seed = xs(seed);
            a = seed[16:0] & 17'h1F00F;
            if (seed[31] || !exp_mem.exists(a)) do_op(1'b1, a, seed[24:17]);
            else do_op(1'b0, a, 8'h00);
        end
        // Contents must survive a long idle spell with no access.
        repeat (50) @(negedge clk_sys);
        do_op(1'b0, 17'h1FFFF, 8'h00);
        close_out();
    end
    initial begin
        #100000;
        errors++;
        close_out();
    end
endmodule // tb
